// ---- bench/config_space_props.sv ----
`timescale 1ns/1ps
module config_space_props
  import config_space_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CFG_STROBE,
  input wire logic        CFG_WRITE,
  input wire logic [2:0]  CFG_FUNC,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic        CFG_ACK,
  input wire logic [31:0] CFG_RDATA,
  input wire bus_event_s  BUS_EVENTS,
  input wire logic        SERR_OE,
  input wire logic [4:0]  UNIT_BUSY,
  input wire logic [4:0]  UNIT_RETRY,
  input wire logic [1:0]  POWER_STATE,
  input wire logic        EE_REQ,
  input wire logic        EE_DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic rd;
  assign rd = CFG_STROBE && !CFG_WRITE && CFG_FUNC == OWN_FUNCTION;
  property p_ack;
    CFG_STROBE && CFG_FUNC == OWN_FUNCTION |=> CFG_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_class;
    rd && CFG_ADDR == OFS_REV_CLASS |=> CFG_RDATA[31:8] == 24'h048000;
  endproperty
  a_class: assert property (p_class) else $error("bad class");
  property p_pcap;
    rd && CFG_ADDR == OFS_PWR_CAP |=> CFG_RDATA == 32'h00220001;
  endproperty
  a_pcap: assert property (p_pcap) else $error("bad power cap");
  property p_pd;
    rd && CFG_ADDR == OFS_PD_CAP |=> CFG_RDATA[15:0] == 16'h4C03;
  endproperty
  a_pd: assert property (p_pd) else $error("bad pd header");
  property p_serr;
    SERR_OE |-> $past(BUS_EVENTS.system_error_request || BUS_EVENTS.addr_parity);
  endproperty
  a_serr: assert property (p_serr) else $error("serr without cause");
  property p_pwr;
    POWER_STATE != 2'h1 && POWER_STATE != 2'h2;
  endproperty
  a_pwr: assert property (p_pwr) else $error("bad power state");
  property p_unit;
    (UNIT_RETRY & ~$past(UNIT_BUSY)) == 5'h0;
  endproperty
  a_unit: assert property (p_unit) else $error("retry on idle unit");
  property p_ee;
    EE_REQ && EE_DONE |=> !EE_REQ;
  endproperty
  a_ee: assert property (p_ee) else $error("request held");
endmodule
bind pci_function_config_space config_space_props i_config_space_props (
  .MCLK, .RST_N, .CFG_STROBE, .CFG_WRITE, .CFG_FUNC, .CFG_ADDR, .CFG_ACK,
  .CFG_RDATA, .BUS_EVENTS, .SERR_OE, .UNIT_BUSY, .UNIT_RETRY, .POWER_STATE,
  .EE_REQ, .EE_DONE
);

// ---- bench/eeprom_model.sv ----
`timescale 1ns/1ps
module eeprom_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [14:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  lat,
  output logic             done,
  output logic [31:0]      rdata
);
  logic [7:0] mem [256];
  logic [7:0] a;
  int         cnt;
  assign a = addr[7:0];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    done = 1'b0;
    rdata = 32'h0;
    cnt = 0;
  end
  // Read data flips every cycle except a read's done cycle so a sampler off the done pulse sees junk.
  always @(posedge clk) begin
    done <= 1'b0;
    rdata <= ~rdata;
    if (req && !done) begin
      cnt <= cnt + 1;
      if (cnt >= int'(lat)) begin
        cnt <= 0;
        done <= 1'b1;
        if (wr) begin
          {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]} <= wdata;
        end else begin
          rdata <= {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]};
        end
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import config_space_pkg::*;
;
  logic        MCLK, RST_N, stb, wr, ack, k, dma, ch, cm, me, mm, eq, ew, ed, oe, so;
  logic [2:0]  fn;
  logic [7:0]  adr;
  logic [3:0]  be, lat;
  logic [31:0] wd, rdata, q, er, ewd;
  logic [4:0]  busy, ur;
  logic [1:0]  pw;
  logic [14:0] ea;
  bus_event_s  ev;
  int          error_cnt, n_compared, cyc;
  logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h34, 8'h40, 8'h44, 8'h4C, 8'h50, 8'h10};
  logic [31:0] rv [9] = '{32'h5A5AA5A5, 32'h02900000, 32'h04800000, 32'h44,
                          32'h001F1F30, 32'h4C03, 32'h00220001, 32'h0, 32'h0};
  logic [1:0]  pv [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [1:0]  pe [4] = '{2'h3, 2'h3, 2'h3, 2'h0};
  pci_function_config_space #(.PART_ID(16'h5A5A), .MAKER_ID(16'hA5A5))
    i_pci_function_config_space (
    .MCLK(MCLK), .RST_N(RST_N), .CFG_STROBE(stb), .CFG_WRITE(wr), .CFG_FUNC(fn),
    .CFG_ADDR(adr), .CFG_BE(be), .CFG_WDATA(wd), .CFG_ACK(ack), .CFG_RDATA(rdata),
    .BUS_EVENTS(ev), .SERR_OUT(so), .SERR_OE(oe), .MASTER_ENABLE(me), .MEMORY_ENABLE(mm),
    .UNIT_BUSY(busy), .UNIT_RETRY(ur), .DMA_RETRY(dma), .DMA_CHANNEL(ch),
    .COMPAT_MODE(cm), .POWER_STATE(pw), .EE_REQ(eq), .EE_WRITE(ew), .EE_ADDR(ea),
    .EE_WDATA(ewd), .EE_DONE(ed), .EE_RDATA(er));
  eeprom_model i_eeprom_model (.clk(MCLK), .req(eq), .wr(ew), .addr(ea), .wdata(ewd),
    .lat(lat), .done(ed), .rdata(er));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0,
                     input logic [2:0] f = 3'h3);
    @(posedge MCLK);
    stb <= 1'b1;
    wr <= w;
    fn <= f;
    adr <= a;
    wd <= d;
    @(posedge MCLK);
    stb <= 1'b0;
    #1;
    k = ack;
    q = rdata;
  endtask
  task automatic pulse(input bus_event_s e, input logic r);
    @(posedge MCLK);
    ev <= e;
    dma <= r;
    @(posedge MCLK);
    ev <= '0;
    dma <= 1'b0;
    #1;
  endtask
  task automatic wee(input logic f);
    q = {32{~f}};
    for (int i = 0; i < 20 && q[31] !== f; i++) begin
      acc(0, 8'h44);
    end
    chk(q[31], f);
    chk(eq, 32'h0);
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    {RST_N, stb, wr, dma, adr, wd, ev, busy, cyc, error_cnt, n_compared} = '0;
    fn = 3'h3;
    be = 4'hF;
    lat = 4'h1;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      acc(0, ra[i]);
      chk(k, 32'h1);
      chk(q, rv[i]);
    end
    acc(0, 8'h00, 32'h0, 3'h2);
    chk(k, 32'h0);
    acc(1, 8'h2C, 32'h12345678);
    acc(0, 8'h2C);
    chk(q, 32'h0);
    acc(1, 8'h40, 32'h00001F39);
    chk(cm, 32'h1);
    acc(1, 8'h2C, 32'h12345678);
    acc(0, 8'h2C);
    chk(q, 32'h12345678);
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h50, {30'h0, pv[i]});
      chk(pw, pe[i]);
    end
    acc(1, 8'h04, 32'h147);
    chk({me, mm}, 32'h3);
    @(posedge MCLK);
    busy <= 5'h1F;
    acc(0, 8'h04);
    chk(q, 32'h02900146);
    chk(ur, 32'h1F);
    acc(1, 8'h40, 32'h39);
    acc(0, 8'h40);
    chk(q, 32'h001F0039);
    chk(ur, 32'h0);
    @(posedge MCLK);
    busy <= 5'h0;
    repeat (3) pulse('0, 1);
    chk(ch, 32'h0);
    pulse('0, 1);
    chk(ch, 32'h1);
    pulse(7'h40, 0);
    chk({so, oe}, 32'h1);
    acc(0, 8'h04);
    chk(q, 32'hC2900146);
    pulse(7'h0E, 0);
    chk(oe, 32'h0);
    acc(0, 8'h04);
    chk(q, 32'hF3900146);
    acc(1, 8'h04, 32'hF1000106);
    acc(0, 8'h04);
    chk(q, 32'h02900106);
    pulse(7'h21, 0);
    pulse(7'h40, 0);
    chk(oe, 32'h0);
    acc(0, 8'h04);
    chk(q, 32'h82900106);
    acc(1, 8'h44, 32'h00120000);
    wee(1'b1);
    acc(0, 8'h44);
    chk(q, 32'h80124C03);
    acc(0, 8'h48);
    chk(q, 32'h4F4E4948);
    @(posedge MCLK);
    lat <= 4'h7;
    acc(1, 8'h48, 32'hCAFEF00D);
    acc(1, 8'h44, 32'h80130000);
    chk({ew, ea}, 32'h8013);
    wee(1'b0);
    acc(0, 8'h44);
    chk(q, 32'h00134C03);
    acc(1, 8'h44, 32'h00130000);
    wee(1'b1);
    acc(0, 8'h48);
    chk(q, 32'hCAFEF00D);
    @(posedge MCLK);
    RST_N <= 1'b0;
    @(posedge MCLK);
    RST_N <= 1'b1;
    acc(0, 8'h04);
    chk(q, 32'h02900000);
    acc(0, 8'h40);
    chk(q, 32'h001F1F30);
    chk({ch, pw}, 32'h0);
    final_report();
  end
endmodule

// ---- logic/config_space_pkg.sv ----
package config_space_pkg;

  // ******************************************************
  // Register byte offsets
  // ******************************************************
  localparam logic [7:0] OFS_ID_PAIR    = 8'h00;
  localparam logic [7:0] OFS_CMD_STAT   = 8'h04;
  localparam logic [7:0] OFS_REV_CLASS  = 8'h08;
  localparam logic [7:0] OFS_SUBSYS     = 8'h2C;
  localparam logic [7:0] OFS_CAP_PTR    = 8'h34;
  localparam logic [7:0] OFS_DEV_CTRL   = 8'h40;
  localparam logic [7:0] OFS_PD_CAP     = 8'h44;
  localparam logic [7:0] OFS_PD_WORD    = 8'h48;
  localparam logic [7:0] OFS_PWR_CAP    = 8'h4C;
  localparam logic [7:0] OFS_PWR_CTRL   = 8'h50;

  // ******************************************************
  // Function decode and constant fields
  // ******************************************************
  localparam logic [2:0]  OWN_FUNCTION    = 3'h3;
  localparam logic [23:0] CLASS_CODE      = 24'h048000;
  localparam logic [7:0]  CAPABILITY_LIST_PRESENT_START  = 8'h34;
  localparam logic [7:0]  FIRST_CAP       = 8'h44;
  localparam logic [7:0]  PD_CAP_ID       = 8'h03;
  localparam logic [7:0]  PD_NEXT_PTR     = 8'h4C;
  localparam logic [7:0]  PWR_CAP_ID      = 8'h01;
  localparam logic [7:0]  PWR_NEXT_PTR    = 8'h00;
  localparam logic [2:0]  PWR_VERSION     = 3'h2;
  localparam logic [1:0]  SELECT_SPEED    = 2'h1;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int POS_READY_EN    = 8;
  localparam int POS_READY_STAT  = 16;
  localparam int POS_RETRY_LIMIT = 4;
  localparam int POS_COMPAT      = 3;
  localparam int POS_SUBSYS_WE   = 0;
  localparam int POS_SPECIAL_INIT = 21;
  localparam int POS_PWR_VERSION = 16;
  localparam int POS_PD_FLAG     = 31;
  localparam int POS_PD_ADDR     = 16;

  // ******************************************************
  // Reset values and power-state codes
  // ******************************************************
  localparam logic [4:0]  RST_READY_EN    = 5'h1F;
  localparam logic [2:0]  RST_RETRY_LIMIT = 3'h3;
  localparam logic [1:0]  RST_POWER_STATE = 2'h0;
  localparam logic [1:0]  PWR_D0          = 2'h0;
  localparam logic [1:0]  PWR_D3_HOT      = 2'h3;

  // ******************************************************
  // Carriers
  // ******************************************************
  typedef struct packed {
    logic addr_parity;
    logic data_parity;
    logic system_error_request;
    logic initiator_abort;
    logic target_abort;
    logic perr_driven_on_read;
    logic perr_seen_on_write;
  } bus_event_s;

  typedef struct packed {
    logic parity_error_detected;
    logic system_error_signalled;
    logic initiator_abort_received;
    logic target_abort_received;
    logic initiator_data_parity_error;
  } error_flags_s;

  typedef enum logic [1:0] {
    PD_IDLE  = 2'b00,
    PD_READ  = 2'b01,
    PD_WRITE = 2'b10
  } pd_state_e;

endpackage

// ---- logic/error_status_tracker.sv ----
`timescale 1ns/1ps
module error_status_tracker
  import config_space_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire bus_event_s   events,
  input  wire error_flags_s clear,
  input  wire logic         system_error_driver_enable,
  input  wire logic         parity_response_enable,
  output error_flags_s      flags,
  output logic              serr_drive
);

  typedef struct packed {
    error_flags_s flags;
    logic         serr_drive;
  } state_s;

  state_s state;
  state_s next_state;
  error_flags_s set;

  // ******************************************************
  // Sticky flags
  // ******************************************************
  // Set terms are ORed after the clear so an event in the
  // clearing cycle survives.
  always_comb begin
    next_state = state;
    next_state.serr_drive = system_error_driver_enable &
      (events.system_error_request |
       (events.addr_parity & parity_response_enable));
    set.parity_error_detected = events.addr_parity | events.data_parity;
    set.system_error_signalled = next_state.serr_drive;
    set.initiator_abort_received = events.initiator_abort;
    set.target_abort_received = events.target_abort;
    set.initiator_data_parity_error = parity_response_enable &
      (events.perr_driven_on_read | events.perr_seen_on_write);
    next_state.flags = (state.flags & ~clear) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
  assign serr_drive = state.serr_drive;

endmodule

// ---- logic/pci_function_config_space.sv ----
// Summary of operation
// - Five unit ready-enable bits reset to one; clear disables that unit's retry logic.
// - Three-bit retry limit, default three, bounds DMA retries before switching channel.
// - One compatibility-mode bit, default zero, applies to all functions.
// - Subsystem ID writes are accepted only while the write-enable bit is one.
// - Done flag sets after a four-byte read, clears after a four-byte write.
// - Product-data header returns ID three and next pointer 4C.
// - Each transfer moves four bytes, low byte at the given address.
// - Power capability returns ID one, version two, next pointer zero.
// - Power capability shows no D1, D2, wake events; special init required.
// - Power-state field is read/write, resets to D0; 11 is D3 hot.
// - Writes requesting D1 or D2 leave the power-state field unchanged.
// - Wake status, enable, data fields and bridge byte read as zero.
// - Configuration accesses are answered only when function number is three.
// - Offset zero returns part identifier high and maker identifier low.
// - Status keeps sticky parity, system error, initiator and target abort bits.
// - Initiator data-parity bit sets on PERR only while parity response enabled.
// - Select timing is medium and target abort signalled always reads zero.
// - SERR driven only when enabled; address parity also needs parity response.
// - Master cycles need initiator enable, memory claims need memory enable; no I/O.
// - Status shows capability list and target back-to-back; class code 048000.
`timescale 1ns/1ps
module pci_function_config_space
  import config_space_pkg::*;
#(
  parameter logic [15:0] PART_ID  = 16'h0A5A, // Arbitrary value.
  parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value.
  parameter logic [7:0]  REVISION = 8'h00  // Arbitrary value.
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CFG_STROBE,
  input  wire logic        CFG_WRITE,
  input  wire logic [2:0]  CFG_FUNC,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic             CFG_ACK,
  output logic [31:0]      CFG_RDATA,
  input  wire bus_event_s  BUS_EVENTS,
  output logic             SERR_OUT,
  output logic             SERR_OE,
  output logic             MASTER_ENABLE,
  output logic             MEMORY_ENABLE,
  input  wire logic [4:0]  UNIT_BUSY,
  output logic [4:0]       UNIT_RETRY,
  input  wire logic        DMA_RETRY,
  output logic             DMA_CHANNEL,
  output logic             COMPAT_MODE,
  output logic [1:0]       POWER_STATE,
  output logic             EE_REQ,
  output logic             EE_WRITE,
  output logic [14:0]      EE_ADDR,
  output logic [31:0]      EE_WDATA,
  input  wire logic        EE_DONE,
  input  wire logic [31:0] EE_RDATA
);

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0]  lanes
  );
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[8*i +: 8] = new_value[8*i +: 8];
      end
    end
    return result;
  endfunction

  // ******************************************************
  // State
  // ******************************************************
  // Subsystem identifiers come up as zero; no EEPROM preload at reset is modelled.
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [4:0]  ready_enable;
    logic [2:0]  arbiter_retry_limit;
    logic        host_bridge_compat_enable;
    logic        subsystem_id_write_enable;
    logic        system_error_driver_enable;
    logic        parity_response_enable;
    logic        write_invalidate_enable;
    logic        bus_initiator_enable;
    logic        memory_space_enable;
    logic [1:0]  current_power_state;
    logic [31:0] subsystem_ids;
    logic [4:0]  unit_retry;
    logic [2:0]  retry_count;
    logic        channel;
  } state_s;

  state_s state;
  state_s next_state;

  logic         hit;
  logic         wr_hit;
  logic [31:0]  wmerged;
  logic [31:0]  read_value;
  logic [31:0]  cmd_stat;
  error_flags_s err_flags;
  error_flags_s err_clear;
  logic         serr_drive;
  logic         pd_start;
  logic         pd_data_write;
  logic         pd_flag;
  logic [14:0]  pd_addr;
  logic [31:0]  pd_data;
  logic         pd_req;
  logic         pd_wr;

  // ******************************************************
  // Decode
  // ******************************************************
  // Accesses to other function numbers are left unanswered.
  assign hit = CFG_STROBE & (CFG_FUNC == OWN_FUNCTION);
  assign wr_hit = hit & CFG_WRITE;
  assign wmerged = CFG_WDATA;

  // Write-one-to-clear only acts when the top status byte lane (CFG_BE[3]) is enabled.
  always_comb begin
    err_clear = '0;
    if (wr_hit && CFG_ADDR == OFS_CMD_STAT && CFG_BE[3]) begin
      err_clear.parity_error_detected = CFG_WDATA[31];
      err_clear.system_error_signalled = CFG_WDATA[30];
      err_clear.initiator_abort_received = CFG_WDATA[29];
      err_clear.target_abort_received = CFG_WDATA[28];
      err_clear.initiator_data_parity_error = CFG_WDATA[24];
    end
  end

  // The address field and flag share the top two lanes, so a
  // start needs both of them written in one access.
  assign pd_start = wr_hit & (CFG_ADDR == OFS_PD_CAP) & (&CFG_BE[3:2]);
  assign pd_data_write = wr_hit & (CFG_ADDR == OFS_PD_WORD);

  // ******************************************************
  // Status tracking and product data transfers
  // ******************************************************
  error_status_tracker u_errors (
    .clk                        (MCLK),
    .rst_n                      (RST_N),
    .events                     (BUS_EVENTS),
    .clear                      (err_clear),
    .system_error_driver_enable (state.system_error_driver_enable),
    .parity_response_enable     (state.parity_response_enable),
    .flags                      (err_flags),
    .serr_drive                 (serr_drive)
  );

  product_data_port u_product_data (
    .clk          (MCLK),
    .rst_n        (RST_N),
    .start        (pd_start),
    .start_flag   (CFG_WDATA[POS_PD_FLAG]),
    .start_addr   (CFG_WDATA[30:16]),
    .data_write   (pd_data_write),
    .data_value   (merge_bytes(pd_data, CFG_WDATA, CFG_BE)),
    .ee_done      (EE_DONE),
    .ee_rdata     (EE_RDATA),
    .done_flag    (pd_flag),
    .byte_address (pd_addr),
    .data_word    (pd_data),
    .ee_req       (pd_req),
    .ee_write     (pd_wr)
  );

  // ******************************************************
  // Read mux
  // ******************************************************
  always_comb begin
    cmd_stat = '0;
    cmd_stat[31] = err_flags.parity_error_detected;
    cmd_stat[30] = err_flags.system_error_signalled;
    cmd_stat[29] = err_flags.initiator_abort_received;
    cmd_stat[28] = err_flags.target_abort_received;
    cmd_stat[27] = 1'b0;
    cmd_stat[26:25] = SELECT_SPEED;
    cmd_stat[24] = err_flags.initiator_data_parity_error;
    cmd_stat[23] = 1'b1;
    cmd_stat[21] = 1'b0;
    cmd_stat[20] = 1'b1;
    cmd_stat[8] = state.system_error_driver_enable;
    cmd_stat[6] = state.parity_response_enable;
    cmd_stat[4] = state.write_invalidate_enable;
    cmd_stat[2] = state.bus_initiator_enable;
    cmd_stat[1] = state.memory_space_enable;
    cmd_stat[0] = 1'b0;
  end

  // Unmapped offsets read as zero; writes to them are acknowledged and dropped.
  always_comb begin
    read_value = '0;
    case (CFG_ADDR)
      OFS_ID_PAIR: begin
        read_value = {PART_ID, MAKER_ID};
      end
      OFS_CMD_STAT: begin
        read_value = cmd_stat;
      end
      OFS_REV_CLASS: begin
        read_value = {CLASS_CODE, REVISION};
      end
      OFS_SUBSYS: begin
        read_value = state.subsystem_ids;
      end
      OFS_CAP_PTR: begin
        read_value[7:0] = FIRST_CAP;
      end
      OFS_DEV_CTRL: begin
        read_value[POS_READY_STAT +: 5] = ~UNIT_BUSY | ~state.ready_enable;
        read_value[POS_READY_EN +: 5] = state.ready_enable;
        read_value[POS_RETRY_LIMIT +: 3] = state.arbiter_retry_limit;
        read_value[POS_COMPAT] = state.host_bridge_compat_enable;
        read_value[POS_SUBSYS_WE] = state.subsystem_id_write_enable;
      end
      OFS_PD_CAP: begin
        read_value = {pd_flag, pd_addr, PD_NEXT_PTR, PD_CAP_ID};
      end
      OFS_PD_WORD: begin
        read_value = pd_data;
      end
      OFS_PWR_CAP: begin
        read_value[POS_SPECIAL_INIT] = 1'b1;
        read_value[POS_PWR_VERSION +: 3] = PWR_VERSION;
        read_value[15:8] = PWR_NEXT_PTR;
        read_value[7:0] = PWR_CAP_ID;
      end
      OFS_PWR_CTRL: begin
        read_value[1:0] = state.current_power_state;
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  // ******************************************************
  // Register writes, unit gating and DMA arbiter
  // ******************************************************
  always_comb begin
    next_state = state;
    next_state.ack = hit;
    next_state.rdata = (hit && !CFG_WRITE) ? read_value : '0;
    // Byte lanes whose enable is low keep their old contents.
    if (wr_hit) begin
      case (CFG_ADDR)
        OFS_CMD_STAT: begin
          if (CFG_BE[1]) begin
            next_state.system_error_driver_enable = wmerged[8];
          end
          if (CFG_BE[0]) begin
            next_state.parity_response_enable = wmerged[6];
            next_state.write_invalidate_enable = wmerged[4];
            next_state.bus_initiator_enable = wmerged[2];
            next_state.memory_space_enable = wmerged[1];
          end
        end
        OFS_SUBSYS: begin
          if (state.subsystem_id_write_enable) begin
            next_state.subsystem_ids =
              merge_bytes(state.subsystem_ids, wmerged, CFG_BE);
          end
        end
        OFS_DEV_CTRL: begin
          if (CFG_BE[1]) begin
            next_state.ready_enable = wmerged[POS_READY_EN +: 5];
          end
          if (CFG_BE[0]) begin
            next_state.arbiter_retry_limit = wmerged[POS_RETRY_LIMIT +: 3];
            next_state.host_bridge_compat_enable = wmerged[POS_COMPAT];
            next_state.subsystem_id_write_enable = wmerged[POS_SUBSYS_WE];
          end
        end
        OFS_PWR_CTRL: begin
          // D1 and D2 are unsupported, so such a write keeps the old state.
          if (CFG_BE[0] &&
              (wmerged[1:0] == PWR_D0 || wmerged[1:0] == PWR_D3_HOT)) begin
            next_state.current_power_state = wmerged[1:0];
          end
        end
        default: begin
          next_state.ack = hit;
        end
      endcase
    end
    // A cleared enable lets accesses through without retry, so
    // software must poll the unit itself.
    next_state.unit_retry = state.ready_enable & UNIT_BUSY;
    // The count restarts on each switch; a limit of zero switches on every retry.
    if (DMA_RETRY && state.bus_initiator_enable) begin
      if (state.retry_count >= state.arbiter_retry_limit) begin
        next_state.retry_count = 3'h0;
        next_state.channel = ~state.channel;
      end else begin
        next_state.retry_count = state.retry_count + 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= '0;
      state.ready_enable <= RST_READY_EN;
      state.arbiter_retry_limit <= RST_RETRY_LIMIT;
      state.current_power_state <= RST_POWER_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign CFG_ACK = state.ack;
  assign CFG_RDATA = state.rdata;
  // The error pin is open drain: only its enable moves, the value stays low.
  assign SERR_OUT = 1'b0;
  assign SERR_OE = serr_drive;
  assign MASTER_ENABLE = state.bus_initiator_enable;
  assign MEMORY_ENABLE = state.memory_space_enable;
  assign UNIT_RETRY = state.unit_retry;
  assign DMA_CHANNEL = state.channel;
  assign COMPAT_MODE = state.host_bridge_compat_enable;
  assign POWER_STATE = state.current_power_state;
  assign EE_REQ = pd_req;
  assign EE_WRITE = pd_wr;
  assign EE_ADDR = pd_addr;
  assign EE_WDATA = pd_data;

endmodule

// ---- logic/product_data_port.sv ----
`timescale 1ns/1ps
module product_data_port
  import config_space_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        start_flag,
  input  wire logic [14:0] start_addr,
  input  wire logic        data_write,
  input  wire logic [31:0] data_value,
  input  wire logic        ee_done,
  input  wire logic [31:0] ee_rdata,
  output logic             done_flag,
  output logic [14:0]      byte_address,
  output logic [31:0]      data_word,
  output logic             ee_req,
  output logic             ee_write
);

  typedef struct packed {
    pd_state_e   fsm;
    logic        flag;
    logic [14:0] addr;
    logic [31:0] data;
    logic        req;
    logic        wr;
  } state_s;

  state_s state;
  state_s next_state;

  // ******************************************************
  // Transfer sequencer
  // ******************************************************
  // A new start while a transfer runs is ignored; the EEPROM
  // engine cannot abort a word already under way.
  always_comb begin
    next_state = state;
    case (state.fsm)
      PD_IDLE: begin
        if (data_write) begin
          next_state.data = data_value;
        end
        if (start) begin
          next_state.flag = start_flag;
          next_state.addr = start_addr;
          next_state.req = 1'b1;
          next_state.wr = start_flag;
          next_state.fsm = start_flag ? PD_WRITE : PD_READ;
        end
      end
      PD_READ: begin
        if (ee_done) begin
          next_state.data = ee_rdata;
          next_state.flag = 1'b1;
          next_state.req = 1'b0;
          next_state.fsm = PD_IDLE;
        end
      end
      PD_WRITE: begin
        if (ee_done) begin
          next_state.flag = 1'b0;
          next_state.req = 1'b0;
          next_state.fsm = PD_IDLE;
        end
      end
      default: begin
        next_state.fsm = PD_IDLE;
        next_state.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done_flag = state.flag;
  assign byte_address = state.addr;
  assign data_word = state.data;
  assign ee_req = state.req;
  assign ee_write = state.wr;

endmodule
